// *** include/dcpr_defs.svh ***
`ifndef DCPR_DEFS_SVH
`define DCPR_DEFS_SVH

// ----------------------------------------
// register byte ranges
// ----------------------------------------
`define DCPR_CKE_OFFSET 12'h660
`define DCPR_CKE_BYTES 4
`define DCPR_REFR_OFFSET 12'h669
`define DCPR_REFR_BYTES 6

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define DCPR_CKE_RESET 32'h0000_0800
`define DCPR_CKE_RW_MASK 32'h0FFF_3FFF
`define DCPR_CKE_LOCK_MASK 32'h00F0_0000
`define DCPR_REFR_RESET 48'h0218_3000_0C30
`define DCPR_REFR_RW_MASK 48'h03FF_FFFF_FFFF

// ----------------------------------------
// cke_power_control fields
// ----------------------------------------
`define DCPR_SR_EXIT_BIT 27
`define DCPR_HIGH_W_MSB 26
`define DCPR_HIGH_W_LSB 24
`define DCPR_RANK1_BIT 21
`define DCPR_RANK0_BIT 20
`define DCPR_LOW_W_MSB 19
`define DCPR_LOW_W_LSB 17
`define DCPR_PD_EN_BIT 16
`define DCPR_TXP_MSB 13
`define DCPR_TXP_LSB 10
`define DCPR_SR_CNT_MSB 9
`define DCPR_SR_CNT_LSB 1
`define DCPR_SINGLE_BIT 0

// ----------------------------------------
// refresh_control fields
// ----------------------------------------
`define DCPR_DIR_Q_MSB 41
`define DCPR_DIR_Q_LSB 37
`define DCPR_IND_Q_MSB 36
`define DCPR_IND_Q_LSB 32
`define DCPR_CW_MSB 31
`define DCPR_CW_LSB 27
`define DCPR_ZQ_EN_BIT 26
`define DCPR_ALL_RANK_BIT 24

// ----------------------------------------
// timing
// ----------------------------------------
`define DCPR_ZQ_INTERVAL_TICKS 128

`endif

// *** include/dcpr_pkg.sv ***
`default_nettype none
package dcpr_pkg;

  typedef enum logic [2:0] {
    DCPR_ACTIVE = 3'h0,
    DCPR_PDOWN = 3'h1,
    DCPR_PD_EXIT = 3'h3,
    DCPR_SELF_REF = 3'h2,
    DCPR_SR_EXIT = 3'h6
  } dcpr_pwr_t;

  typedef struct packed {
    logic busy;
    logic [4:0] cnt;
    logic grant;
  } dcpr_wait_st_t;

  typedef struct packed {
    logic [2:0] req;
    logic [2:0] grant;
  } dcpr_comp_t;

  typedef struct packed {
    logic [31:0] cke_ctl;
    logic [47:0] refr_ctl;
    logic [7:0] rdata;
    dcpr_pwr_t state;
    logic cke;
    logic [1:0] cke_rank;
    logic [2:0] pw_cnt;
    logic [8:0] wait_cnt;
    logic [7:0] zq_cnt;
    logic zq_cmd;
  } dcpr_st_t;

endpackage : dcpr_pkg
`default_nettype wire

// *** hw/dcpr_tick_wait.sv ***
`timescale 1ns/1ns
`default_nettype none

// waits a number of refresh ticks, then grants one pending request
module dcpr_tick_wait (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [4:0] window,
  input wire logic bypass,
  input wire logic refresh_tick,
  output logic grant
);

  dcpr_pkg::dcpr_wait_st_t st_reg;
  dcpr_pkg::dcpr_wait_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.grant = 1'b0;
    if (!st_reg.busy) begin
      // hold off one cycle after a grant so the requester can drop req
      if (req && !st_reg.grant) begin
        if (bypass || window == 5'h00) begin
          st_next.grant = 1'b1;
        end else begin
          st_next.busy = 1'b1;
          st_next.cnt = window;
        end
      end
    end else if (refresh_tick) begin
      if (st_reg.cnt == 5'h01) begin
        st_next.busy = 1'b0;
        st_next.grant = 1'b1;
      end
      st_next.cnt = st_reg.cnt - 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign grant = st_reg.grant;

endmodule : dcpr_tick_wait

`default_nettype wire

// *** hw/dcpr_ctl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dcpr_defs.svh"

// Behaviour
// - setting the self-refresh exit bit starts the self-refresh exit sequence
// - cke stays high at least the high-phase width before dropping
// - cke stays low at least the low-phase width before rising
// - two lockable rank presence bits, rank1 at 21, rank0 at 20, reset zero
// - power-down cke toggling only while power-down enable is set
// - after power-down exit, wait programmed 2..15 clocks before non-read commands
// - after self-refresh exit, wait the 9-bit exit count before commands
// - single-module bit tells that only one module is fitted, reset zero
// - independent mode: wait direct quiet ticks before direct compensation
// - independent mode: wait indirect quiet ticks before indirect compensation
// - zq enable set issues periodic zq short commands, clear issues none
// - all-rank select clear: staggered refresh; set: independent rank refresh
module dcpr_ctl #(
  parameter int ZQ_INTERVAL_TICKS = `DCPR_ZQ_INTERVAL_TICKS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic cfg_lock,
  input wire logic powerdown_req,
  input wire logic self_refresh_req,
  input wire logic refresh_tick,
  input wire dcpr_pkg::dcpr_comp_t comp_in,
  output dcpr_pkg::dcpr_comp_t comp_out,
  output logic [1:0] cke_rank,
  output logic cmd_allowed,
  output logic read_allowed,
  output logic zq_short_cmd,
  output logic rank1_present,
  output logic rank0_present,
  output logic single_module_present,
  output logic independent_rank_refresh
);

  // the interval counter is eight bits wide
  if (ZQ_INTERVAL_TICKS < 1 || ZQ_INTERVAL_TICKS > 255) begin : g_bad_zq
    $error("ZQ_INTERVAL_TICKS must lie in 1..255");
  end

  localparam logic [7:0] ZQ_LAST = 8'(ZQ_INTERVAL_TICKS - 1);

  dcpr_pkg::dcpr_st_t st_reg;
  dcpr_pkg::dcpr_st_t st_next;
  logic [2:0] grant;

  // ----------------------------------------
  // byte decode
  // ----------------------------------------
  // returns 1 and the byte index when addr falls in [base, base+n)
  function automatic logic in_range(input logic [11:0] addr, input logic [11:0] base,
                                    input int n, output logic [2:0] idx);
    logic [11:0] d;
    d = addr - base;
    idx = d[2:0];
    in_range = (addr >= base) && (d < 12'(n));
  endfunction : in_range

  logic cke_hit;
  logic refr_hit;
  logic [2:0] cke_idx;
  logic [2:0] refr_idx;

  always_comb begin
    cke_hit = in_range(reg_addr, `DCPR_CKE_OFFSET, `DCPR_CKE_BYTES, cke_idx);
    refr_hit = in_range(reg_addr, `DCPR_REFR_OFFSET, `DCPR_REFR_BYTES, refr_idx);
  end

  // ----------------------------------------
  // field views
  // ----------------------------------------
  logic [2:0] high_w;
  logic [2:0] low_w;
  logic pd_en;
  logic [3:0] txp;
  logic [8:0] sr_cnt;
  logic zq_en;
  logic indep;

  assign high_w = st_reg.cke_ctl[`DCPR_HIGH_W_MSB:`DCPR_HIGH_W_LSB];
  assign low_w = st_reg.cke_ctl[`DCPR_LOW_W_MSB:`DCPR_LOW_W_LSB];
  assign pd_en = st_reg.cke_ctl[`DCPR_PD_EN_BIT];
  assign txp = st_reg.cke_ctl[`DCPR_TXP_MSB:`DCPR_TXP_LSB];
  assign sr_cnt = st_reg.cke_ctl[`DCPR_SR_CNT_MSB:`DCPR_SR_CNT_LSB];
  assign zq_en = st_reg.refr_ctl[`DCPR_ZQ_EN_BIT];
  assign indep = st_reg.refr_ctl[`DCPR_ALL_RANK_BIT];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [31:0] cke_wmask;
  logic [47:0] refr_wmask;
  logic [31:0] cke_wr;
  logic [47:0] refr_wr;
  logic pw_done;

  always_comb begin
    st_next = st_reg;
    cke_wmask = '0;
    refr_wmask = '0;
    if (reg_wr && cke_hit) begin
      cke_wmask[8*cke_idx +: 8] = 8'hFF;
    end
    if (reg_wr && refr_hit) begin
      refr_wmask[8*refr_idx +: 8] = 8'hFF;
    end
    cke_wmask = cke_wmask & `DCPR_CKE_RW_MASK;
    if (cfg_lock) begin
      cke_wmask = cke_wmask & ~`DCPR_CKE_LOCK_MASK;
    end
    refr_wmask = refr_wmask & `DCPR_REFR_RW_MASK;
    cke_wr = {4{reg_wdata}};
    refr_wr = {6{reg_wdata}};

    // register reads, unmapped bytes read zero
    st_next.rdata = 8'h00;
    if (reg_rd && cke_hit) begin
      st_next.rdata = st_reg.cke_ctl[8*cke_idx +: 8];
    end else if (reg_rd && refr_hit) begin
      st_next.rdata = st_reg.refr_ctl[8*refr_idx +: 8];
    end

    // power state machine
    pw_done = (st_reg.pw_cnt == 3'h0);
    if (!pw_done) begin
      st_next.pw_cnt = st_reg.pw_cnt - 3'h1;
    end
    if (st_reg.wait_cnt != 9'h000) begin
      st_next.wait_cnt = st_reg.wait_cnt - 9'h001;
    end
    case (st_reg.state)
      dcpr_pkg::DCPR_ACTIVE: begin
        if (self_refresh_req && pw_done) begin
          st_next.state = dcpr_pkg::DCPR_SELF_REF;
          st_next.cke = 1'b0;
          st_next.pw_cnt = low_w;
        end else if (pd_en && powerdown_req && pw_done) begin
          st_next.state = dcpr_pkg::DCPR_PDOWN;
          st_next.cke = 1'b0;
          st_next.pw_cnt = low_w;
        end
      end
      dcpr_pkg::DCPR_PDOWN: begin
        if (!powerdown_req && pw_done) begin
          st_next.state = dcpr_pkg::DCPR_PD_EXIT;
          st_next.cke = 1'b1;
          st_next.pw_cnt = high_w;
          st_next.wait_cnt = {5'h00, txp};
        end
      end
      dcpr_pkg::DCPR_PD_EXIT: begin
        // reserved spacing codes below 2 collapse to one clock
        if (st_reg.wait_cnt <= 9'h001) begin
          st_next.state = dcpr_pkg::DCPR_ACTIVE;
          st_next.wait_cnt = 9'h000;
        end
      end
      dcpr_pkg::DCPR_SELF_REF: begin
        if (st_reg.cke_ctl[`DCPR_SR_EXIT_BIT] && pw_done) begin
          st_next.state = dcpr_pkg::DCPR_SR_EXIT;
          st_next.cke = 1'b1;
          st_next.pw_cnt = high_w;
          st_next.wait_cnt = sr_cnt;
          st_next.cke_ctl[`DCPR_SR_EXIT_BIT] = 1'b0;
        end
      end
      dcpr_pkg::DCPR_SR_EXIT: begin
        if (st_reg.wait_cnt <= 9'h001) begin
          st_next.state = dcpr_pkg::DCPR_ACTIVE;
          st_next.wait_cnt = 9'h000;
        end
      end
      default: begin
        st_next.state = dcpr_pkg::DCPR_ACTIVE;
        st_next.cke = 1'b1;
      end
    endcase

    // software write applied after the hardware clear, so a set wins
    st_next.cke_ctl = (st_next.cke_ctl & ~cke_wmask) | (cke_wr & cke_wmask);
    st_next.refr_ctl = (st_reg.refr_ctl & ~refr_wmask) | (refr_wr & refr_wmask);

    // absent ranks keep cke low
    st_next.cke_rank = {2{st_next.cke}}
                       & {st_reg.cke_ctl[`DCPR_RANK1_BIT], st_reg.cke_ctl[`DCPR_RANK0_BIT]};

    // periodic zq short, counted only in the active state
    st_next.zq_cmd = 1'b0;
    if (!zq_en) begin
      st_next.zq_cnt = 8'h00;
    end else if (refresh_tick && st_reg.state == dcpr_pkg::DCPR_ACTIVE) begin
      if (st_reg.zq_cnt >= ZQ_LAST) begin
        st_next.zq_cnt = 8'h00;
        st_next.zq_cmd = 1'b1;
      end else begin
        st_next.zq_cnt = st_reg.zq_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.cke_ctl <= `DCPR_CKE_RESET;
      st_reg.refr_ctl <= `DCPR_REFR_RESET;
      st_reg.state <= dcpr_pkg::DCPR_ACTIVE;
      st_reg.cke <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // compensation quiet windows
  // ----------------------------------------
  logic [4:0] windows [3];

  assign windows[0] = st_reg.refr_ctl[`DCPR_DIR_Q_MSB:`DCPR_DIR_Q_LSB];
  assign windows[1] = st_reg.refr_ctl[`DCPR_IND_Q_MSB:`DCPR_IND_Q_LSB];
  assign windows[2] = st_reg.refr_ctl[`DCPR_CW_MSB:`DCPR_CW_LSB];

  for (genvar g = 0; g < 3; g++) begin : g_comp
    dcpr_tick_wait u_wait (
      .mclk(mclk),
      .rst_n(rst_n),
      .req(comp_in.req[g]),
      .window(windows[g]),
      .bypass(!indep),
      .refresh_tick(refresh_tick),
      .grant(grant[g])
    );
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = st_reg.rdata;
  assign comp_out = {3'h0, grant};
  assign cke_rank = st_reg.cke_rank;
  assign cmd_allowed = (st_reg.state == dcpr_pkg::DCPR_ACTIVE);
  assign read_allowed = (st_reg.state == dcpr_pkg::DCPR_ACTIVE)
                        || (st_reg.state == dcpr_pkg::DCPR_PD_EXIT);
  assign zq_short_cmd = st_reg.zq_cmd;
  assign rank1_present = st_reg.cke_ctl[`DCPR_RANK1_BIT];
  assign rank0_present = st_reg.cke_ctl[`DCPR_RANK0_BIT];
  assign single_module_present = st_reg.cke_ctl[`DCPR_SINGLE_BIT];
  assign independent_rank_refresh = indep;

endmodule : dcpr_ctl

`default_nettype wire

// *** dv/dcpr_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------
// port checks
// ----------------
module dcpr_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic powerdown_req,
  input wire logic self_refresh_req,
  input wire logic refresh_tick,
  input wire dcpr_pkg::dcpr_comp_t comp_in,
  input wire dcpr_pkg::dcpr_comp_t comp_out,
  input wire logic [1:0] cke_rank,
  input wire logic cmd_allowed,
  input wire logic read_allowed,
  input wire logic zq_short_cmd,
  input wire logic rank0_present,
  input wire logic independent_rank_refresh
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  property p_rank_off;
    !rank0_present && !$past(rank0_present) |-> !cke_rank[0];
  endproperty
  a_rank_off: assert property (p_rank_off) else $error("absent rank has cke");
  property p_pd_cause;
    $fell(cke_rank[0]) |-> $past(powerdown_req) || $past(self_refresh_req);
  endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("cke fell unrequested");
  property p_txp_min;
    $rose(read_allowed) && !cmd_allowed |-> !cmd_allowed [*2];
  endproperty
  a_txp_min: assert property (p_txp_min) else $error("exit spacing short");
  property p_cmd_read;
    cmd_allowed |-> read_allowed;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("cmd without read");
  property p_zq;
    zq_short_cmd |-> $past(refresh_tick) ##1 !zq_short_cmd;
  endproperty
  a_zq: assert property (p_zq) else $error("zq pulse bad");
  property p_dir;
    comp_out.grant[0] |-> $past(comp_in.req[0]) ##1 !comp_out.grant[0];
  endproperty
  a_dir: assert property (p_dir) else $error("direct grant bad");
  property p_ind;
    comp_out.grant[1] |-> $past(comp_in.req[1]) ##1 !comp_out.grant[1];
  endproperty
  a_ind: assert property (p_ind) else $error("indirect grant bad");
  property p_imm;
    $rose(comp_in.req[2]) && !independent_rank_refresh |=> comp_out.grant[2];
  endproperty
  a_imm: assert property (p_imm) else $error("no prompt grant");
endmodule : dcpr_chk
bind dcpr_ctl dcpr_chk dcpr_chk_inst (.mclk, .rst_n, .powerdown_req, .self_refresh_req,
  .refresh_tick, .comp_in, .comp_out, .cke_rank, .cmd_allowed, .read_allowed,
  .zq_short_cmd, .rank0_present, .independent_rank_refresh);
`default_nettype wire

// *** dv/dcpr_dram_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------
// rank model
// ----------------
module dcpr_dram_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic zq,
  output logic [7:0] low_run,
  output logic [7:0] high_run,
  output logic [7:0] zq_seen
);
  logic [7:0] run;
  logic prev;
  // level run lengths; early values are junk until a full pulse passes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run <= 8'h00;
      prev <= 1'b0;
      low_run <= 8'h00;
      high_run <= 8'h00;
      zq_seen <= 8'h00;
    end else begin
      prev <= cke;
      run <= (cke == prev) ? run + 8'h01 : 8'h01;
      if (cke != prev && prev) high_run <= run;
      if (cke != prev && !prev) low_run <= run;
      if (zq) zq_seen <= zq_seen + 8'h01;
    end
  end
endmodule : dcpr_dram_model
`default_nettype wire

// *** dv/dcpr_ctl_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dcpr_defs.svh"
// ----------------
// bench
// ----------------
module dcpr_ctl_tb;
  logic mclk, rst_n, reg_wr, reg_rd, cfg_lock, powerdown_req, self_refresh_req, refresh_tick;
  logic cmd_allowed, read_allowed, zq_short_cmd, rank1_present, rank0_present, single_p, indep;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, low_run, high_run, zq_seen;
  logic [1:0] cke_rank;
  dcpr_pkg::dcpr_comp_t comp_in, comp_out;
  int failures, cmp_count, cyc;
  dcpr_ctl #(.ZQ_INTERVAL_TICKS(4)) dcpr_ctl_inst (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .cfg_lock, .powerdown_req, .self_refresh_req, .refresh_tick,
    .comp_in, .comp_out, .cke_rank, .cmd_allowed, .read_allowed, .zq_short_cmd, .rank1_present,
    .rank0_present, .single_module_present(single_p), .independent_rank_refresh(indep));
  dcpr_dram_model dcpr_dram_model_inst (.mclk, .rst_n, .cke(cke_rank[0]), .zq(zq_short_cmd),
    .low_run, .high_run, .zq_seen);
  task automatic step;
    @(posedge mclk);
    #2;
  endtask : step
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    step();
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    check(reg_rdata, e);
    step();
  endtask : rc
  task automatic wait_cke(input logic [1:0] v);
    repeat (60) begin
      if (cke_rank === v) break;
      step();
    end
  endtask : wait_cke
  task automatic comp(input int u, input logic [7:0] w);
    logic [7:0] t;
    int k;
    t = 8'h00;
    k = 0;
    comp_in.req[u] = 1'b1;
    // ticks three cycles apart so grant latency cannot blur the count
    repeat (200) begin
      step();
      if (comp_out.grant[u] === 1'b1) break;
      k++;
      refresh_tick = (k % 3 == 0);
      t = t + {7'h00, refresh_tick};
    end
    refresh_tick = 1'b0;
    comp_in.req[u] = 1'b0;
    check(t, w);
    step();
  endtask : comp
  task automatic t_regs;
    logic [47:0] v;
    logic [47:0] r;
    v = 48'(`DCPR_CKE_RESET);
    r = `DCPR_REFR_RESET;
    for (int i = 0; i < 6; i++) begin
      if (i < 4) begin
        rc(12'h660 + 12'(i), v[8*i+:8]);
      end
      rc(12'h669 + 12'(i), r[8*i+:8]);
    end
    rc(12'h664, 8'h00);
    check({rank1_present, rank0_present, single_p, indep}, 4'h0);
    v = 48'h0335_0C0B;
    for (int i = 0; i < 4; i++) begin
      wr(12'h660 + 12'(i), v[8*i+:8]);
    end
    rc(12'h660, 8'h0B);
    check({rank1_present, rank0_present, single_p}, 3'b111);
    cfg_lock = 1'b1;
    wr(12'h662, 8'h05);
    rc(12'h662, 8'h35);
    cfg_lock = 1'b0;
    $display("test regs done");
  endtask : t_regs
  task automatic t_pdown;
    logic [7:0] n;
    n = 8'h00;
    powerdown_req = 1'b1;
    wait_cke(2'b00);
    check(cke_rank, 2'b00);
    powerdown_req = 1'b0;
    repeat (40) begin
      step();
      if (cmd_allowed === 1'b1) break;
      n = n + {7'h00, read_allowed};
    end
    check(n >= 8'h03, 1'b1);
    check(low_run >= 8'h02, 1'b1);
    powerdown_req = 1'b1;
    wait_cke(2'b00);
    step();
    check(high_run >= 8'h03, 1'b1);
    powerdown_req = 1'b0;
    wait_cke(2'b11);
    wr(12'h662, 8'h34);
    powerdown_req = 1'b1;
    repeat (10) step();
    check(cke_rank, 2'b11);
    powerdown_req = 1'b0;
    $display("test power-down done");
  endtask : t_pdown
  task automatic t_sref;
    logic [7:0] n;
    n = 8'h00;
    self_refresh_req = 1'b1;
    wait_cke(2'b00);
    self_refresh_req = 1'b0;
    reg_addr = 12'h663;
    reg_wdata = 8'h0B;
    reg_wr = 1'b1;
    repeat (60) begin
      step();
      reg_wr = 1'b0;
      if (cmd_allowed === 1'b1) break;
      n = n + 8'h01;
    end
    check(n >= 8'h05, 1'b1);
    check(cke_rank, 2'b11);
    rc(12'h663, 8'h03);
    $display("test self-refresh done");
  endtask : t_sref
  task automatic t_comp;
    wr(12'h66E, 8'h00);
    wr(12'h66D, 8'h23);
    wr(12'h66C, 8'h15);
    check(indep, 1'b1);
    comp(0, 8'h01);
    comp(1, 8'h03);
    comp(2, 8'h02);
    check(zq_seen, 8'h01);
    wr(12'h66C, 8'h10);
    comp(2, 8'h00);
    check(comp_out.req, 3'h0);
    $display("test compensation done");
  endtask : t_comp
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, cfg_lock} = '0;
    {powerdown_req, self_refresh_req, refresh_tick} = '0;
    comp_in = '0;
    rst_n = 1'b0;
    repeat (6) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    t_regs();
    t_pdown();
    t_sref();
    t_comp();
    end_of_test();
  end
endmodule : dcpr_ctl_tb
`default_nettype wire
